// File: bench/frp_ctrl_model.sv
// behavioural protocol controller on the ttl port
`timescale 1ns/1ps
module frp_ctrl_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic hold,
    input wire logic [39:0] frame,
    output logic rx_ttl,
    output logic tx_req
);
    logic req_q;
    assign tx_req = req_q | hold;
    initial begin
        rx_ttl = 1'b1;
        req_q = 1'b0;
        forever begin
            @(posedge mclk iff go);
            @(negedge mclk);
            req_q = 1'b1;
            repeat (3) @(negedge mclk);
            for (int i = 0; i < 40; i++) begin
                rx_ttl = frame[i];
                repeat (10) @(negedge mclk);
            end
            // released line returns to its pull-up level
            rx_ttl = 1'b1;
            req_q = 1'b0;
        end
    end
endmodule

// File: bench/frp_repeater_assertions.sv
// port assertions for the three-port repeater
`timescale 1ns/1ps
module frp_repeater_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_a,
    input wire logic rx_b,
    input wire logic rx_ttl,
    input wire logic tx_req,
    input wire logic retime_sel,
    input wire logic tx_a,
    input wire logic tx_b,
    input wire logic tx_ttl,
    input wire logic tx_ttl_echo,
    input wire logic locked_a,
    input wire logic locked_b
);
    logic [9:0] quiet_q;
    logic calm;
    assign calm = rx_a && rx_b && rx_ttl && !tx_req && tx_a && tx_b && tx_ttl && !locked_a && !locked_b;
    // counts fully idle cycles, saturating
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            quiet_q <= 10'h000;
        end else if (!calm) begin
            quiet_q <= 10'h000;
        end else if (quiet_q != 10'h3FF) begin
            quiet_q <= quiet_q + 10'h001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_echo;
        tx_ttl_echo == rx_ttl;
    endproperty
    a_echo: assert property (p_echo) else $error("echo mismatch");
    property p_one_lock;
        !(locked_a && locked_b);
    endproperty
    a_one_lock: assert property (p_one_lock) else $error("two sources locked");
    property p_own_a;
        locked_a |-> tx_a;
    endproperty
    a_own_a: assert property (p_own_a) else $error("source port transmits");
    property p_same_out;
        locked_a |-> tx_b == tx_ttl;
    endproperty
    a_same_out: assert property (p_same_out) else $error("outputs differ");
    property p_hold;
        $rose(locked_a) |-> locked_a [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("lock dropped early");
    property p_late;
        $rose(locked_a) |-> tx_b [*8];
    endproperty
    a_late: assert property (p_late) else $error("output too early");
    property p_start;
        ($fell(rx_a) && rx_b && rx_ttl && !tx_req && quiet_q == 10'h3FF) |-> ##[1:6] locked_a;
    endproperty
    a_start: assert property (p_start) else $error("no lock on activity");
    property p_req;
        (tx_req && $past(tx_req) && $past(tx_req, 2) && $past(tx_req, 3) && $past(tx_req, 4)) |-> !$rose(locked_a);
    endproperty
    a_req: assert property (p_req) else $error("fiber locked during request");
endmodule

// File: bench/tb.sv
// testbench for the three-port repeater
`timescale 1ns/1ps
module tb;
    localparam logic [39:0] FRAME = 40'hC35A96E138;
    logic mclk, rst, retime_sel, go, hold, rx_ttl, tx_req, tx_a, tx_b, tx_ttl, tx_ttl_echo, locked_a, locked_b;
    logic [1:0] rx;
    int n_errors = 0;
    int n_checks = 0;
    frp_repeater frp_repeater_i (.mclk(mclk), .rst(rst), .rx_a(rx[0]), .rx_b(rx[1]), .rx_ttl(rx_ttl),
        .tx_req(tx_req), .retime_sel(retime_sel), .tx_a(tx_a), .tx_b(tx_b), .tx_ttl(tx_ttl),
        .tx_ttl_echo(tx_ttl_echo), .locked_a(locked_a), .locked_b(locked_b));
    frp_ctrl_model frp_ctrl_model_i (.mclk(mclk), .go(go), .hold(hold), .frame(FRAME), .rx_ttl(rx_ttl),
        .tx_req(tx_req));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? tx_a : (w == 1 ? tx_b : tx_ttl);
    endfunction
    // waits for the first bit on a line, then samples each bit mid-period
    task automatic cap(input int w, output logic [39:0] got, output int lat);
        lat = 0;
        while (pick(w) !== 1'b0) begin
            @(negedge mclk);
            lat++;
            if (lat > 2000) begin
                n_errors++;
                close_out();
            end
        end
        repeat (5) @(negedge mclk);
        for (int i = 0; i < 40; i++) begin
            got[i] = pick(w);
            repeat (10) @(negedge mclk);
        end
    endtask
    task automatic drive(input int w, input logic [39:0] f);
        for (int i = 0; i < 40; i++) begin
            rx[w] = f[i];
            repeat (10) @(negedge mclk);
        end
        rx[w] = 1'b1;
    endtask
    // frame on one fiber, noise on the other after the lock
    task automatic s_fiber(input int w);
        logic [39:0] g1;
        logic [39:0] g2;
        int lat;
        int lat2;
        repeat (1100) @(negedge mclk);
        fork
            drive(w, FRAME);
            begin
                repeat (20) @(negedge mclk);
                chk({39'h0, w ? locked_b : locked_a}, 40'h1);
                drive(1 - w, ~FRAME);
            end
            cap(1 - w, g1, lat);
            cap(2, g2, lat2);
        join
        chk(g1, FRAME);
        chk(g2, FRAME);
        chk({39'h0, lat >= 300}, 40'h1);
    endtask
    task automatic s_ttl(input logic sel);
        logic [39:0] g1;
        logic [39:0] g2;
        int lat;
        retime_sel = sel;
        repeat (1100) @(negedge mclk);
        go = 1'b1;
        @(negedge mclk);
        go = 1'b0;
        fork
            cap(0, g1, lat);
            cap(1, g2, lat);
            begin
                repeat (350) @(negedge mclk);
                chk({39'h0, tx_ttl}, 40'h1);
                chk({39'h0, tx_ttl_echo}, {39'h0, rx_ttl});
            end
        join
        chk(g1, FRAME);
        chk(g2, FRAME);
    endtask
    task automatic s_hold();
        repeat (1100) @(negedge mclk);
        hold = 1'b1;
        repeat (20) @(negedge mclk);
        drive(0, FRAME);
        chk({38'h0, locked_a, tx_b}, 40'h1);
        hold = 1'b0;
    endtask
    initial begin
        rst = 1'b1;
        rx = 2'b11;
        retime_sel = 1'b1;
        go = 1'b0;
        hold = 1'b0;
        repeat (16) @(negedge mclk);
        chk({34'h0, tx_a, tx_b, tx_ttl, tx_ttl_echo, locked_a, locked_b}, 40'h3C);
        rst = 1'b0;
        s_fiber(0);
        s_fiber(1);
        s_ttl(1'b1);
        s_ttl(1'b0);
        s_hold();
        close_out();
    end
endmodule
bind frp_repeater frp_repeater_assertions frp_repeater_assertions_i (.mclk(mclk), .rst(rst), .rx_a(rx_a),
    .rx_b(rx_b), .rx_ttl(rx_ttl), .tx_req(tx_req), .retime_sel(retime_sel), .tx_a(tx_a), .tx_b(tx_b),
    .tx_ttl(tx_ttl), .tx_ttl_echo(tx_ttl_echo), .locked_a(locked_a), .locked_b(locked_b));

// File: src/frp_bit_mem.sv
// bit memory for the drift fifo, registered read
`timescale 1ns/1ps
module frp_bit_mem (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [frp_pkg::FIFO_AW-1:0] wr_addr,
    input wire logic wr_bit,
    input wire logic [frp_pkg::FIFO_AW-1:0] rd_addr,
    output logic rd_bit
);
    logic [frp_pkg::FIFO_DEPTH-1:0] mem_q;

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_bit;
        end
    end

    always_ff @(posedge mclk) begin
        rd_bit <= mem_q[rd_addr];
    end
endmodule

// File: src/frp_pkg.sv
// shared constants for the three-port fiber repeater
package frp_pkg;
    // main clock period in ns
    localparam int MCLK_PERIOD_NS = 8;
    // bit period of the line, as a count of main clock cycles
    localparam int BIT_CYCLES = 10;
    // mid-bit sampling point in cycles after an edge
    localparam int SAMPLE_POINT = BIT_CYCLES / 2;
    // bit fifo
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_AW = 6;
    localparam logic [FIFO_AW:0] FIFO_HALF = 7'h20;
    // idle time that ends a frame, in ns, and its cycle count
    localparam int IDLE_END_NS = 2000;
    localparam int IDLE_END_CYCLES = (IDLE_END_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int IDLE_CW = 9;
    localparam logic IDLE_LEVEL = 1'b1;
    // source selector codes
    typedef enum logic [2:0] {
        FRP_SRC_A = 3'b001,
        FRP_SRC_B = 3'b010,
        FRP_SRC_T = 3'b100
    } frp_src_type;
    typedef enum logic [2:0] {
        FRP_IDLE = 3'b001,
        FRP_FILL = 3'b010,
        FRP_SEND = 3'b100
    } frp_state_type;
endpackage

// File: src/frp_repeater.sv
// three-port repeater: input lock, retimer, bit fifo, transmit switch, ttl echo
`timescale 1ns/1ps
module frp_repeater (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_a,
    input wire logic rx_b,
    input wire logic rx_ttl,
    input wire logic tx_req,
    input wire logic retime_sel,
    output logic tx_a,
    output logic tx_b,
    output logic tx_ttl,
    output logic tx_ttl_echo,
    output logic locked_a,
    output logic locked_b
);
    // synchronisers, first stage read only by second
    logic [1:0] a_s_q;
    logic [1:0] b_s_q;
    logic [1:0] t_s_q;
    logic [1:0] r_s_q;
    logic [1:0] m_s_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_s_q <= 2'h3;
            b_s_q <= 2'h3;
            t_s_q <= 2'h3;
            r_s_q <= 2'h0;
            m_s_q <= 2'h0;
        end else begin
            a_s_q <= {a_s_q[0], rx_a};
            b_s_q <= {b_s_q[0], rx_b};
            t_s_q <= {t_s_q[0], rx_ttl};
            r_s_q <= {r_s_q[0], tx_req};
            m_s_q <= {m_s_q[0], retime_sel};
        end
    end

    logic a_in;
    logic b_in;
    logic t_in;
    logic req_in;
    logic reti;
    assign a_in = a_s_q[1];
    assign b_in = b_s_q[1];
    assign t_in = t_s_q[1];
    assign req_in = r_s_q[1];
    assign reti = m_s_q[1];

    function automatic logic active(input logic lvl);
        active = (lvl != frp_pkg::IDLE_LEVEL);
    endfunction

    // last cycle of a local bit slot
    function automatic logic slot_end(input logic [3:0] cnt);
        slot_end = (cnt == 4'(frp_pkg::BIT_CYCLES - 1));
    endfunction

    // frame bit on a port, idle level on the locked source
    function automatic logic route(input frp_pkg::frp_src_type src, input frp_pkg::frp_src_type port,
        input logic b);
        route = (src != port) ? b : frp_pkg::IDLE_LEVEL;
    endfunction

    // lock flag of one fiber port
    function automatic logic lock_of(input logic on, input frp_pkg::frp_src_type src,
        input frp_pkg::frp_src_type port);
        lock_of = on && (src == port);
    endfunction

    frp_pkg::frp_state_type state_q;
    frp_pkg::frp_src_type src_q;
    logic [frp_pkg::IDLE_CW-1:0] idle_cnt_q;
    logic sel_line;
    logic sel_busy;
    logic bypass;
    logic fifo_empty;
    logic idle_done;
    logic frame_on;

    // a frame is in progress from lock until release
    assign frame_on = (state_q != frp_pkg::FRP_IDLE);

    // selected source line and its activity; the others are ignored
    always_comb begin
        unique case (src_q)
            frp_pkg::FRP_SRC_A: begin
                sel_line = a_in;
                sel_busy = active(a_in);
            end
            frp_pkg::FRP_SRC_B: begin
                sel_line = b_in;
                sel_busy = active(b_in);
            end
            default: begin
                sel_line = t_in;
                sel_busy = active(t_in) || req_in;
            end
        endcase
    end

    // ttl source with retimer off goes round the retimer
    assign bypass = (src_q == frp_pkg::FRP_SRC_T) && !reti;

    // quiet time on the locked input
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_cnt_q <= '0;
        end else if (state_q == frp_pkg::FRP_IDLE || sel_busy) begin
            idle_cnt_q <= '0;
        end else if (!idle_done) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end
    assign idle_done = (idle_cnt_q == frp_pkg::IDLE_CW'(frp_pkg::IDLE_END_CYCLES));

    // retimer and bypass bit stream
    logic rt_valid;
    logic rt_bit;
    logic [3:0] by_cnt_q;
    logic by_valid;

    frp_retimer u_retimer (
        .mclk(mclk),
        .rst(rst),
        .enable(frame_on && !bypass),
        .line_in(sel_line),
        .bit_valid(rt_valid),
        .bit_val(rt_bit)
    );

    // bypass samples each bit slot once, at a fixed count, without edge realignment
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            by_cnt_q <= 4'h0;
        end else if (state_q == frp_pkg::FRP_IDLE || !bypass) begin
            by_cnt_q <= 4'h0;
        end else if (slot_end(by_cnt_q)) begin
            by_cnt_q <= 4'h0;
        end else begin
            by_cnt_q <= by_cnt_q + 4'h1;
        end
    end
    assign by_valid = bypass && (by_cnt_q == 4'(frp_pkg::SAMPLE_POINT));

    logic in_valid;
    logic in_bit;
    assign in_valid = bypass ? by_valid : rt_valid;
    assign in_bit = bypass ? sel_line : rt_bit;

    // bit fifo with read pacing at the local bit rate
    logic [frp_pkg::FIFO_AW:0] wr_ptr_q;
    logic [frp_pkg::FIFO_AW:0] rd_ptr_q;
    logic [frp_pkg::FIFO_AW:0] level;
    logic [3:0] out_cnt_q;
    logic out_tick;
    logic rd_bit;
    logic wr_ok;
    logic rd_go;

    assign level = wr_ptr_q - rd_ptr_q;
    assign fifo_empty = (level == '0);
    // writes stop once the line is quiet, so the fifo can drain
    assign wr_ok = in_valid && frame_on && !idle_done
        && (level != (frp_pkg::FIFO_HALF << 1));
    assign out_tick = slot_end(out_cnt_q);
    assign rd_go = out_tick && (state_q == frp_pkg::FRP_SEND) && !fifo_empty;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (state_q == frp_pkg::FRP_IDLE) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (wr_ok) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (rd_go) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_cnt_q <= 4'h0;
        end else if (state_q != frp_pkg::FRP_SEND || out_tick) begin
            out_cnt_q <= 4'h0;
        end else begin
            out_cnt_q <= out_cnt_q + 4'h1;
        end
    end

    frp_bit_mem u_mem (
        .mclk(mclk),
        .wr_en(wr_ok),
        .wr_addr(wr_ptr_q[frp_pkg::FIFO_AW-1:0]),
        .wr_bit(in_bit),
        .rd_addr(rd_ptr_q[frp_pkg::FIFO_AW-1:0]),
        .rd_bit(rd_bit)
    );

    // lock state machine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= frp_pkg::FRP_IDLE;
            src_q <= frp_pkg::FRP_SRC_T;
        end else begin
            unique case (state_q)
                frp_pkg::FRP_IDLE: begin
                    if (req_in || active(t_in)) begin
                        src_q <= frp_pkg::FRP_SRC_T;
                        state_q <= frp_pkg::FRP_FILL;
                    end else if (active(a_in)) begin
                        src_q <= frp_pkg::FRP_SRC_A;
                        state_q <= frp_pkg::FRP_FILL;
                    end else if (active(b_in)) begin
                        src_q <= frp_pkg::FRP_SRC_B;
                        state_q <= frp_pkg::FRP_FILL;
                    end
                end
                frp_pkg::FRP_FILL: begin
                    if (level >= frp_pkg::FIFO_HALF || (idle_done && !fifo_empty)) begin
                        state_q <= frp_pkg::FRP_SEND;
                    end else if (idle_done) begin
                        state_q <= frp_pkg::FRP_IDLE;
                    end
                end
                frp_pkg::FRP_SEND: begin
                    if (idle_done && fifo_empty && out_tick) begin
                        state_q <= frp_pkg::FRP_IDLE;
                    end
                end
                default: begin
                    state_q <= frp_pkg::FRP_IDLE;
                end
            endcase
        end
    end

    // transmit switch; bit held for a whole local bit period
    logic hold_q;
    logic sending_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b1;
            sending_q <= 1'b0;
        end else begin
            sending_q <= rd_go;
            if (sending_q) begin
                hold_q <= rd_bit;
            end else if (state_q == frp_pkg::FRP_IDLE) begin
                hold_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_a <= 1'b1;
            tx_b <= 1'b1;
            tx_ttl <= 1'b1;
        end else begin
            tx_a <= route(src_q, frp_pkg::FRP_SRC_A, hold_q);
            tx_b <= route(src_q, frp_pkg::FRP_SRC_B, hold_q);
            tx_ttl <= route(src_q, frp_pkg::FRP_SRC_T, hold_q);
        end
    end

    // lock flags for the fiber ports
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            locked_a <= 1'b0;
            locked_b <= 1'b0;
        end else begin
            locked_a <= lock_of(frame_on, src_q, frp_pkg::FRP_SRC_A);
            locked_b <= lock_of(frame_on, src_q, frp_pkg::FRP_SRC_B);
        end
    end

    // echo straight from the pin, gated only by reset
    always_comb begin
        tx_ttl_echo = rx_ttl | rst;
    end
endmodule

// File: src/frp_retimer.sv
// oversampling retimer: recovers bits at mid-period from the line
`timescale 1ns/1ps
module frp_retimer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic line_in,
    output logic bit_valid,
    output logic bit_val
);
    logic [3:0] cnt_q;
    logic prev_q;

    // edges realign the phase; the bit is sampled at mid-period
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            prev_q <= 1'b1;
            bit_valid <= 1'b0;
            bit_val <= 1'b1;
        end else begin
            prev_q <= line_in;
            bit_valid <= 1'b0;
            if (!enable) begin
                cnt_q <= 4'h0;
            end else if (line_in != prev_q) begin
                cnt_q <= 4'h1;
            end else begin
                if (cnt_q == 4'(frp_pkg::SAMPLE_POINT)) begin
                    bit_valid <= 1'b1;
                    bit_val <= line_in;
                end
                if (cnt_q == 4'(frp_pkg::BIT_CYCLES - 1)) begin
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule
